// File: hdl/fpec_pkg.sv
// Shared constants and types for the flash program/erase controller.
// Assumes a 32-bit Avalon-MM slave port with byte addresses and one system clock.
package fpec_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses
	localparam logic [4:0] ADDR_CTRL   = 5'h00;   // flash_operation_control
	localparam logic [4:0] ADDR_KEY    = 5'h04;   // unlock_key, write only
	localparam logic [4:0] ADDR_TBLPTR = 5'h08;   // table_page_pointer and offset
	localparam logic [4:0] ADDR_LATCH  = 5'h0c;   // holding latch at pointer
	localparam logic [4:0] ADDR_STATUS = 5'h10;   // controller state

	// Control register fields
	localparam int BIT_START   = 15;
	localparam int BIT_ENABLE  = 14;
	localparam int BIT_ERROR   = 13;
	localparam int BIT_PROGRAM_WITHOUT_ERASE = 12;
	localparam int BIT_ERASE   = 6;
	localparam int CMD_MSB     = 5;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// Status register fields
	localparam int STAT_BUSY   = 0;
	localparam int STAT_SERIAL = 1;
	localparam int STAT_KEY_LO = 2;

	// Unlock key values
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Array geometry
	localparam int ROW_WORDS = 32;
	localparam int WORD_W    = 24;
	localparam int IDX_W     = 5;

	// Operation command codes
	localparam logic [5:0] CMD_ERASE_ROW  = 6'h18;
	localparam logic [5:0] CMD_ERASE_4ROW = 6'h1a;

	typedef enum logic [1:0] {
		KEY_LOCKED,
		KEY_GOT_FIRST,
		KEY_OPEN
	} fpec_key_t;

	typedef enum logic [3:0] {
		OP_NONE,
		OP_ERASE_ROW,
		OP_ERASE_4ROW,
		OP_ERASE_CFG,
		OP_ERASE_EEDATA,
		OP_ERASE_GENERAL,
		OP_ERASE_BOOT,
		OP_ERASE_ALL,
		OP_PROG_ROW
	} fpec_op_t;

	// Request toward the flash array
	typedef struct packed {
		logic              start;   // Launch op, one cycle
		logic              wr;      // Row word transfer, one cycle
		fpec_op_t          op;      // Operation
		logic [23:0]       addr;    // Target address
		logic [WORD_W-1:0] wdata;   // Row word
	} fpec_arr_req_t;

endpackage : fpec_pkg

// File: hdl/fpec_ctrl.sv
// Flash program/erase sequencer with key unlock, row holding latches and Avalon-MM registers.
// Assumes the flash array answers on clk_sys with a done or abort pulse after each launch.
`timescale 1ns/1ps

// Function
// RULE1: Key writes 55h then AAh back to back open the way for an operation.
// RULE2: Key register is write only and reads back zero.
// RULE3: Start bit 15 launches the operation; hardware clears it at the end.
// RULE4: Processor bus is stalled while an operation runs.
// RULE5: Software can only set start; reset zero; zero means idle.
// RULE6: Enable bit 14 permits operations; zero blocks them.
// RULE7: Error bit 13 set on bad start or early end, clear on normal completion.
// RULE8: Erase bit 6 selects erase, otherwise program, for the next start.
// RULE9: Erase codes: one row, four rows, configuration, data EEPROM, general block.
// RULE10: Boot block and whole memory erase only in serial programming mode.
// RULE11: Program code 0001xx writes one full row from the latches.
// RULE12: Unassigned command codes do nothing when started.
// RULE13: Row erase and row program take their rows from the table pointer.
// RULE14: Program-only bit 12 has no effect on flash operations.
// RULE15: Control bits 11 to 7 read as zero.
// RULE16: Software fills 32 latches and sets program mode before row program.
// RULE17: Software sets command, pointer, unlock pair, then start for row erase.
// RULE18: Software places two idle instructions after setting start.
// RULE19: No operation proceeds without the unlock pair just before.
// RULE20: After unlock, control accepts one update, then locks again.
// RULE21: Table stores land in holding latches; array changes only on program.
// RULE22: Software issues 32 table stores to fill a whole row.
// RULE23: Any access other than the exact key pair relocks the unlock machine.
// RULE24: Start while locked or disabled launches nothing and sets the error flag.
module fpec_ctrl (
	input  wire logic                   clk_sys,          // System clock, 125 MHz
	input  wire logic                   nrst,             // Async reset, active low
	input  wire logic [4:0]             avs_address,      // Byte address
	input  wire logic                   avs_read,         // Read request
	input  wire logic                   avs_write,        // Write request
	input  wire logic [31:0]            avs_writedata,    // Write data
	input  wire logic [3:0]             avs_byteenable,   // Byte lanes
	output logic      [31:0]            avs_readdata,     // Read data
	output logic                        avs_waitrequest,  // Stall, high by default
	input  wire logic                   serial_mode_pin,  // Serial programming mode pin
	input  wire logic                   arr_done,         // Array op finished, pulse
	input  wire logic                   arr_abort,        // Array op cut short, pulse
	output fpec_pkg::fpec_arr_req_t     arr_req,          // Request to flash array
	output logic                        cpu_stall         // Processor stall
);

	////////////////////////////////////////////////////////////////////////////
	// Types and helpers
	typedef enum logic [1:0] {
		S_IDLE,
		S_LOAD,
		S_FIRE,
		S_WAIT
	} fpec_state_t;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] fpec_merge(input logic [31:0] old_v, input logic [31:0] new_v,
	                                           input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : fpec_merge

	// Command decode; boot and whole-memory erase need serial mode
	function automatic fpec_pkg::fpec_op_t fpec_decode(input logic erase, input logic [5:0] cmd,
	                                                   input logic serial);
		fpec_pkg::fpec_op_t r;
		r = fpec_pkg::OP_NONE;
		if (erase) begin
			if (cmd == fpec_pkg::CMD_ERASE_ROW) begin
				r = fpec_pkg::OP_ERASE_ROW; // RULE9
			end else if (cmd == fpec_pkg::CMD_ERASE_4ROW) begin
				r = fpec_pkg::OP_ERASE_4ROW; // RULE9
			end else if (cmd[5:2] == 4'b0101) begin
				r = fpec_pkg::OP_ERASE_CFG; // RULE9
			end else if (cmd[5:2] == 4'b0100) begin
				r = fpec_pkg::OP_ERASE_EEDATA; // RULE9
			end else if (cmd[5:2] == 4'b0011) begin
				r = fpec_pkg::OP_ERASE_GENERAL; // RULE9
			end else if (cmd[5:2] == 4'b1010 && serial) begin
				r = fpec_pkg::OP_ERASE_BOOT; // RULE10
			end else if (cmd[5:2] == 4'b1001 && serial) begin
				r = fpec_pkg::OP_ERASE_ALL; // RULE10
			end
		end else if (cmd[5:2] == 4'b0001) begin
			r = fpec_pkg::OP_PROG_ROW; // RULE8 RULE11
		end
		return r; // RULE12
	endfunction : fpec_decode

	////////////////////////////////////////////////////////////////////////////
	// State
	logic                           wait_q;
	logic [31:0]                    rdata_q;
	logic [1:0]                     ser_sync_q;
	logic                           start_q;
	logic                           enable_q;
	logic                           error_q;
	logic                           program_without_erase_q;
	logic                           erase_q;
	logic [5:0]                     cmd_q;
	fpec_pkg::fpec_op_t             op_q;
	fpec_pkg::fpec_key_t            key_q;
	logic [23:0]                    ptr_q;
	logic [fpec_pkg::WORD_W-1:0]    latch_q [fpec_pkg::ROW_WORDS];
	fpec_state_t                    state_q;
	logic [fpec_pkg::IDX_W-1:0]     idx_q;
	fpec_pkg::fpec_arr_req_t        req_q;

	logic        acc;
	logic        acc_wr;
	logic        ctrl_wr;
	logic        start_try;
	logic        launch;
	logic        bad_start;
	logic        finish;
	logic        fail;
	logic [15:0] ctrl_rd;
	logic [31:0] ctrl_new;
	logic [23:0] row_base;

	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;
	assign arr_req         = req_q;
	assign cpu_stall       = start_q;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode; an access takes effect in the cycle waitrequest is low
	assign acc       = (avs_read | avs_write) & ~wait_q;
	assign acc_wr    = avs_write & ~wait_q;
	assign ctrl_wr   = acc_wr && avs_address == fpec_pkg::ADDR_CTRL;
	assign ctrl_new  = fpec_merge({16'h0000, ctrl_rd}, avs_writedata, avs_byteenable);
	assign start_try = ctrl_wr && ctrl_new[fpec_pkg::BIT_START] && !start_q;
	assign launch    = start_try && key_q == fpec_pkg::KEY_OPEN
	                   && ctrl_new[fpec_pkg::BIT_ENABLE]; // RULE1 RULE6 RULE19
	assign bad_start = start_try && !launch; // RULE24
	assign ctrl_rd   = {start_q, enable_q, error_q, program_without_erase_q, 5'h00, erase_q, cmd_q}; // RULE15
	// Erase and program rows are aligned to the block size
	assign row_base  = (op_q == fpec_pkg::OP_ERASE_4ROW)
	                   ? {ptr_q[23:fpec_pkg::IDX_W+3], {(fpec_pkg::IDX_W+3){1'b0}}}
	                   : {ptr_q[23:fpec_pkg::IDX_W+1], {(fpec_pkg::IDX_W+1){1'b0}}}; // RULE13

	// Waitrequest: one wait cycle, held high for the whole operation
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !((avs_read | avs_write) && wait_q && !start_q); // RULE4
		end
	end

	// Read data, captured as waitrequest drops
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && wait_q && !start_q) begin
			unique case (avs_address)
				fpec_pkg::ADDR_CTRL:   rdata_q <= {16'h0000, ctrl_rd};
				fpec_pkg::ADDR_TBLPTR: rdata_q <= {8'h00, ptr_q};
				fpec_pkg::ADDR_LATCH:  rdata_q <= {8'h00, latch_q[ptr_q[fpec_pkg::IDX_W:1]]};
				fpec_pkg::ADDR_STATUS: rdata_q <= {28'h0000000, key_q, ser_sync_q[1], start_q};
				default:               rdata_q <= 32'h0000_0000; // RULE2
			endcase
		end
	end

	// Serial mode pin synchroniser
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ser_sync_q <= 2'b00;
		end else begin
			ser_sync_q <= {ser_sync_q[0], serial_mode_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Unlock machine; the open window lasts for one access only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			key_q <= fpec_pkg::KEY_LOCKED;
		end else if (acc) begin
			unique case (key_q)
				fpec_pkg::KEY_LOCKED: begin
					if (acc_wr && avs_address == fpec_pkg::ADDR_KEY && avs_byteenable[0]
					    && avs_writedata[7:0] == fpec_pkg::KEY_FIRST) begin
						key_q <= fpec_pkg::KEY_GOT_FIRST; // RULE1
					end
				end
				fpec_pkg::KEY_GOT_FIRST: begin
					if (acc_wr && avs_address == fpec_pkg::ADDR_KEY && avs_byteenable[0]
					    && avs_writedata[7:0] == fpec_pkg::KEY_SECOND) begin
						key_q <= fpec_pkg::KEY_OPEN; // RULE1
					end else begin
						key_q <= fpec_pkg::KEY_LOCKED; // RULE23
					end
				end
				fpec_pkg::KEY_OPEN: begin
					key_q <= fpec_pkg::KEY_LOCKED; // RULE20
				end
				default: key_q <= fpec_pkg::KEY_LOCKED;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control fields written by software; program-only is stored, not used here
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			enable_q  <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_ENABLE];
			program_without_erase_q <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_PROGRAM_WITHOUT_ERASE]; // RULE14
			erase_q   <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_ERASE];
			cmd_q     <= fpec_pkg::CTRL_RESET[fpec_pkg::CMD_MSB:0];
		end else if (ctrl_wr && !start_q) begin
			enable_q  <= ctrl_new[fpec_pkg::BIT_ENABLE]; // RULE6
			program_without_erase_q <= ctrl_new[fpec_pkg::BIT_PROGRAM_WITHOUT_ERASE];
			erase_q   <= ctrl_new[fpec_pkg::BIT_ERASE]; // RULE8
			cmd_q     <= ctrl_new[fpec_pkg::CMD_MSB:0];
		end
	end

	// Start bit: set only by a launch, cleared only by the sequencer
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			start_q <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_START];
			op_q    <= fpec_pkg::OP_NONE;
		end else if (launch) begin
			start_q <= 1'b1; // RULE3 RULE5
			op_q    <= fpec_decode(ctrl_new[fpec_pkg::BIT_ERASE], ctrl_new[fpec_pkg::CMD_MSB:0],
			                       ser_sync_q[1]);
		end else if (finish) begin
			start_q <= 1'b0; // RULE3
		end
	end

	// Error flag: hardware set beats a software clear in the same cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			error_q <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_ERROR];
		end else if (bad_start || fail) begin
			error_q <= 1'b1; // RULE7 RULE24
		end else if (launch) begin
			error_q <= 1'b0; // RULE7
		end else if (ctrl_wr) begin
			error_q <= ctrl_new[fpec_pkg::BIT_ERROR];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Table pointer and holding latches; stores never touch the array
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ptr_q <= 24'h000000;
		end else if (acc_wr && avs_address == fpec_pkg::ADDR_TBLPTR) begin
			ptr_q <= 24'(fpec_merge({8'h00, ptr_q}, avs_writedata, avs_byteenable)); // RULE13
		end
	end

	// Latch contents are data only, so no reset
	always_ff @(posedge clk_sys) begin
		if (acc_wr && avs_address == fpec_pkg::ADDR_LATCH) begin
			latch_q[ptr_q[fpec_pkg::IDX_W:1]] <= fpec_pkg::WORD_W'(fpec_merge({8'h00, latch_q[ptr_q[fpec_pkg::IDX_W:1]]},
			                                                avs_writedata, avs_byteenable)); // RULE21
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer: stream row words, fire, wait for the array
	assign fail   = state_q != S_IDLE && arr_abort; // RULE7
	assign finish = (state_q == S_IDLE && start_q && op_q == fpec_pkg::OP_NONE)
	                || (state_q == S_WAIT && arr_done) || fail;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			idx_q   <= '0;
		end else if (fail) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					idx_q <= '0;
					if (start_q && op_q == fpec_pkg::OP_PROG_ROW) begin
						state_q <= S_LOAD; // RULE11
					end else if (start_q && op_q != fpec_pkg::OP_NONE) begin
						state_q <= S_FIRE;
					end
				end
				S_LOAD: begin
					idx_q <= idx_q + 1'b1;
					if (idx_q == fpec_pkg::IDX_W'(fpec_pkg::ROW_WORDS - 1)) begin
						state_q <= S_FIRE;
					end
				end
				S_FIRE: state_q <= S_WAIT;
				S_WAIT: begin
					if (arr_done) begin
						state_q <= S_IDLE; // RULE3
					end
				end
			endcase
		end
	end

	// Array request, pulses last one cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			req_q <= '0;
		end else begin
			req_q.start <= 1'b0;
			req_q.wr    <= 1'b0;
			if (state_q == S_LOAD && !fail) begin
				req_q.wr    <= 1'b1; // RULE21
				req_q.op    <= op_q;
				req_q.addr  <= row_base | {18'h0, idx_q, 1'b0};
				req_q.wdata <= latch_q[idx_q];
			end else if (state_q == S_FIRE && !fail) begin
				req_q.start <= 1'b1;
				req_q.op    <= op_q;
				req_q.addr  <= row_base; // RULE13
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	key_read_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE2
		avs_read && !avs_waitrequest && avs_address == fpec_pkg::ADDR_KEY |-> avs_readdata == 32'h0)
		else $error("key register read returned data");

	start_unlock_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE19
		$rose(start_q) |-> $past(key_q) == fpec_pkg::KEY_OPEN && $past(avs_write)
		&& $past(ctrl_new[fpec_pkg::BIT_ENABLE]))
		else $error("operation started without unlock");

	bad_start_err_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE24
		bad_start |=> error_q && !start_q)
		else $error("improper start not flagged");

	bus_stall_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE4
		start_q |-> avs_waitrequest)
		else $error("bus answered during operation");

	ctrl_reserved_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE15
		avs_read && !avs_waitrequest && avs_address == fpec_pkg::ADDR_CTRL |-> avs_readdata[11:7] == 5'h00)
		else $error("reserved control bits not zero");

	unlock_window_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE20
		key_q == fpec_pkg::KEY_OPEN && acc |=> key_q == fpec_pkg::KEY_LOCKED)
		else $error("unlock window outlived one access");

	prog_stream_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE11
		state_q == S_IDLE && start_q && op_q == fpec_pkg::OP_PROG_ROW && !arr_abort
		|=> ##1 req_q.wr [*8] ##0 req_q.addr[fpec_pkg::IDX_W:1] == 5'd7)
		else $error("row program did not stream latches");

	done_clears_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE3
		state_q == S_WAIT && arr_done && !arr_abort |=> !start_q && !error_q && state_q == S_IDLE)
		else $error("completion did not clear start");

	abort_err_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE7
		fail |=> error_q && !start_q)
		else $error("early end not flagged");

	serial_only_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RULE10
		$rose(start_q) && (op_q == fpec_pkg::OP_ERASE_BOOT || op_q == fpec_pkg::OP_ERASE_ALL)
		|-> $past(ser_sync_q[1]))
		else $error("serial-only erase outside serial mode");

endmodule : fpec_ctrl

// File: tb/fpec_array_model.sv
// Behavioural flash array that answers launches from the sequencer.
// Assumes one clock shared with the sequencer and the request struct of the package.
`timescale 1ns/1ps

module fpec_array_model #(
	parameter int DLY = 20                            // Cycles from launch to answer
) (
	input  wire logic                    clk_sys,     // System clock
	input  wire logic                    nrst,        // Async reset, active low
	input  wire fpec_pkg::fpec_arr_req_t arr_req,     // Request from sequencer
	input  wire logic                    abort_req,   // Bench asks for a cut-short op
	output logic                         arr_done,    // Finish pulse
	output logic                         arr_abort,   // Abort pulse
	output int                           n_start,     // Launches seen
	output int                           n_wr,        // Row words seen
	output fpec_pkg::fpec_op_t           last_op,     // Last launched op
	output logic [23:0]                  last_addr    // Last launched address
);
	logic [23:0] mem [0:31];
	int          cnt;

	////////////////////////////////////////////////////////////////////////////
	// Words land in the row store; a launch answers after DLY, never at once
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt       <= 0;
			arr_done  <= 1'b0;
			arr_abort <= 1'b0;
			n_start   <= 0;
			n_wr      <= 0;
			last_op   <= fpec_pkg::OP_NONE;
			last_addr <= 24'h000000;
		end else begin
			arr_done  <= 1'b0;
			arr_abort <= 1'b0;
			if (arr_req.wr) begin
				mem[arr_req.addr[5:1]] <= arr_req.wdata;
				n_wr                   <= n_wr + 1;
			end
			if (arr_req.start) begin
				cnt       <= DLY;
				n_start   <= n_start + 1;
				last_op   <= arr_req.op;
				last_addr <= arr_req.addr;
			end else if (cnt == 1) begin
				cnt       <= 0;
				arr_done  <= !abort_req;
				arr_abort <= abort_req;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end
		end
	end

endmodule : fpec_array_model

// File: tb/testbench.sv
// Self-checking bench for the flash program/erase sequencer over Avalon-MM.
// Assumes the array model answers each launch after a fixed delay.
`timescale 1ns/1ps

module testbench;
	logic                    clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
	logic [4:0]              avs_address;
	logic [31:0]             avs_writedata, avs_readdata, r;
	logic                    serial_mode_pin, arr_done, arr_abort, cpu_stall, abort_req;
	fpec_pkg::fpec_arr_req_t arr_req;
	fpec_pkg::fpec_op_t      last_op;
	logic [23:0]             last_addr;
	int                      n_start, n_wr, fail_count, samples_checked;
	// Operation table: control word, serial pin, expected op, error, row address
	logic [15:0]             tv [0:10] = '{16'hc058, 16'hc05a, 16'hc055, 16'hc052, 16'hc04f, 16'hc068,
	                                      16'hc068, 16'hc067, 16'hc07f, 16'hd004, 16'h8058};
	logic                    ts [0:10] = '{0, 0, 0, 0, 0, 0, 1, 1, 0, 0, 0};
	logic                    te [0:10] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1};
	logic [23:0]             ta [0:10] = '{24'h001280, 24'h001200, 0, 0, 0, 0, 0, 0, 0, 24'h001280, 0};
	fpec_pkg::fpec_op_t      to [0:10] = '{fpec_pkg::OP_ERASE_ROW, fpec_pkg::OP_ERASE_4ROW,
		fpec_pkg::OP_ERASE_CFG, fpec_pkg::OP_ERASE_EEDATA, fpec_pkg::OP_ERASE_GENERAL, fpec_pkg::OP_NONE,
		fpec_pkg::OP_ERASE_BOOT, fpec_pkg::OP_ERASE_ALL, fpec_pkg::OP_NONE, fpec_pkg::OP_PROG_ROW,
		fpec_pkg::OP_NONE};

	////////////////////////////////////////////////////////////////////////////
	fpec_ctrl dut (
		.clk_sys         (clk_sys),
		.nrst            (nrst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (4'hf),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.serial_mode_pin (serial_mode_pin),
		.arr_done        (arr_done),
		.arr_abort       (arr_abort),
		.arr_req         (arr_req),
		.cpu_stall       (cpu_stall)
	);

	fpec_array_model u_arr (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.arr_req   (arr_req),
		.abort_req (abort_req),
		.arr_done  (arr_done),
		.arr_abort (arr_abort),
		.n_start   (n_start),
		.n_wr      (n_wr),
		.last_op   (last_op),
		.last_addr (last_addr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Verdict, reached from the end of the sequence or a timeout
	task automatic finish_test;
		if (fail_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	// One bus access; held until waitrequest low, which may last a whole operation
	task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_write     <= we;
		avs_read      <= !we;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 3000);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 3000) begin
			fail_count++;
			$display("wrong value at %0t: bus access never answered", $time);
			finish_test();
		end
	endtask : bus

	// Key mode 0 none, 1 proper pair, 2 access between keys, 3 access after keys
	task automatic do_op(input logic [15:0] cv, input logic sm, input logic ab, input logic [1:0] um,
		input fpec_pkg::fpec_op_t eo, input logic ee, input logic [23:0] ea);
		int ns;
		ns = n_start;
		serial_mode_pin <= sm;
		abort_req       <= ab;
		if (um != 2'd0) bus(1'b1, fpec_pkg::ADDR_KEY, 32'h00000055, r);
		if (um == 2'd2) bus(1'b0, fpec_pkg::ADDR_STATUS, 32'h0, r);
		if (um == 2'd2) chk(r, 32'h00000004, "status after first key");
		if (um != 2'd0) bus(1'b1, fpec_pkg::ADDR_KEY, 32'h000000aa, r);
		if (um == 2'd3) bus(1'b0, fpec_pkg::ADDR_CTRL, 32'h0, r);
		bus(1'b1, fpec_pkg::ADDR_CTRL, {16'h0000, cv}, r);
		if (eo != fpec_pkg::OP_NONE) begin
			@(posedge clk_sys);
			#1;
			chk(32'(cpu_stall), 32'h1, "stall while running");
		end
		bus(1'b0, fpec_pkg::ADDR_CTRL, 32'h0, r);
		chk(r, {16'h0000, (cv & 16'h507f) | (16'(ee) << 13)}, "control after op");
		chk(32'(n_start - ns), 32'(eo != fpec_pkg::OP_NONE), "launch count");
		if (eo != fpec_pkg::OP_NONE) chk(32'(last_op), 32'(eo), "op code");
		if (ea != 24'h0) chk({8'h00, last_addr}, {8'h00, ea}, "row address");
	endtask : do_op

	////////////////////////////////////////////////////////////////////////////
	// Free-running 125 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Main sequence
	initial begin
		nrst = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		serial_mode_pin = 1'b0;
		abort_req = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		bus(1'b0, fpec_pkg::ADDR_CTRL, 32'h0, r);
		chk(r, 32'h0, "control reset");
		bus(1'b1, 5'h14, 32'hffffffff, r);
		bus(1'b0, 5'h14, 32'h0, r);
		chk(r, 32'h0, "unmapped read");
		bus(1'b1, fpec_pkg::ADDR_KEY, 32'h00000055, r);
		bus(1'b0, fpec_pkg::ADDR_KEY, 32'h0, r);
		chk(r, 32'h0, "key read");
		// Fill the whole row of latches; the array must stay untouched
		for (int i = 0; i < 32; i++) begin
			bus(1'b1, fpec_pkg::ADDR_TBLPTR, 32'(32'h1280 + 2 * i), r);
			bus(1'b1, fpec_pkg::ADDR_LATCH, 32'(32'h5a0300 + i), r);
		end
		chk(32'(n_wr), 32'h0, "array untouched by latch loads");
		bus(1'b0, fpec_pkg::ADDR_TBLPTR, 32'h0, r);
		chk(r, 32'h000012be, "pointer read back");
		bus(1'b0, fpec_pkg::ADDR_LATCH, 32'h0, r);
		chk(r, 32'h005a031f, "latch read back");
		bus(1'b1, fpec_pkg::ADDR_TBLPTR, 32'h000012a6, r);
		for (int k = 0; k < 11; k++)
			do_op(tv[k], ts[k], 1'b0, 2'd1, to[k], te[k], ta[k]);
		chk(32'(n_wr), 32'd32, "row words sent");
		for (int i = 0; i < 32; i++)
			chk({8'h00, u_arr.mem[i]}, 32'(32'h5a0300 + i), "programmed word");
		do_op(16'hc058, 1'b0, 1'b0, 2'd0, fpec_pkg::OP_NONE, 1'b1, 24'h0);
		do_op(16'hc058, 1'b0, 1'b0, 2'd2, fpec_pkg::OP_NONE, 1'b1, 24'h0);
		do_op(16'hc058, 1'b0, 1'b0, 2'd3, fpec_pkg::OP_NONE, 1'b1, 24'h0);
		do_op(16'hc058, 1'b0, 1'b1, 2'd1, fpec_pkg::OP_ERASE_ROW, 1'b1, 24'h001280);
		finish_test();
	end

endmodule : testbench
